// ===== rtl/mccp_ctr.sv
/*
 One 48-bit counter: increment, software load of either word, clear, overflow pulse.
 Assumes load and clear come from the register port of the same clock.
*/
`timescale 1ns/100ps
module mccp_ctr
    import mccp_pkg::*;
#(
    parameter int IW = INC_W
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [IW-1:0]     inc,
    input  wire logic              count_en,
    input  wire logic              clr,
    input  wire logic              ld_lo,
    input  wire logic              ld_hi,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [CTR_W-1:0]  count,
    output logic                   ovf
);
    mccp_cnt_s      s_r;
    mccp_cnt_s      s_nxt;
    logic [CTR_W:0] sum;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ovf = 1'b0;
        sum = {1'b0, s_r.cnt} + (CTR_W + 1)'(inc);
        if (clr) begin
            s_nxt.cnt = '0;
        end else if (ld_lo) begin
            s_nxt.cnt[DATA_W-1:0] = wdata;
        end else if (ld_hi) begin
            s_nxt.cnt[CTR_W-1:DATA_W] = wdata[HI_W-1:0];
        end else if (count_en) begin
            {s_nxt.ovf, s_nxt.cnt} = sum; // Wraps modulo 2**48 on overflow, keeping the excess
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign count = s_r.cnt;
    assign ovf   = s_r.ovf;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_cnt_step: assert property (
        count_en && !clr && !ld_lo && !ld_hi |=> count == $past(count) + CTR_W'($past(inc)))
        else $error("counter step wrong");
    a_ovf_carry: assert property (
        ovf |-> count < CTR_W'($past(inc)) && $past(count_en))
        else $error("overflow without carry");
endmodule

// ===== rtl/mccp_irq.sv
/*
 Sticky overflow status, write-one clear and enable; one level interrupt.
 Assumes set pulses and register strobes on the same clock.
*/
`timescale 1ns/100ps
module mccp_irq
    import mccp_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic [NUM_IRQ-1:0] set,
    input  wire logic               clr_wr,
    input  wire logic               en_wr,
    input  wire logic [DATA_W-1:0]  wdata,
    output logic      [NUM_IRQ-1:0] status,
    output logic      [NUM_IRQ-1:0] enable,
    output logic                    irq
);
    mccp_irq_s s_r;
    mccp_irq_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (clr_wr) begin
            s_nxt.status = s_r.status & ~wdata[NUM_IRQ-1:0];
        end
        // A set in the clearing cycle survives
        s_nxt.status = s_nxt.status | set;
        if (en_wr) begin
            s_nxt.enable = wdata[NUM_IRQ-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{status: '0, enable: IRQ_EN_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign status = s_r.status;
    assign enable = s_r.enable;
    assign irq    = |(s_r.status & s_r.enable);
endmodule

// ===== rtl/mccp_pkg.sv
/*
 Package for the memory channel performance counters: map, fields, reset values, carriers.
 Assumes one 125 MHz clock and a 32-bit register port with byte addresses.
*/
package mccp_pkg;
    // ----------------------------------------------------------------
    // Structure
    // ----------------------------------------------------------------
    localparam int NUM_CH     = 2;
    localparam int NUM_PROG   = 4;
    localparam int NUM_CTR    = 5;
    localparam int FIX_IDX    = 4;
    localparam int CTR_W      = 48;
    localparam int INC_W      = 4;
    localparam int MAX_INC    = 8;
    localparam int EVSEL_W    = 8;
    localparam int BYTE_W     = 8;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int NUM_IRQ    = NUM_CH * NUM_CTR;
    localparam int HI_W       = CTR_W - DATA_W;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTL_EN_BIT  = 22;
    localparam int CTL_ARM_BIT = 20;
    localparam int CTL_CLR_BIT = 19;
    localparam logic [31:0] PROG_CTL_MASK = 32'h0050_00ff;
    localparam logic [31:0] FIX_CTL_MASK  = 32'h0050_0000;
    localparam logic [31:0] CTL_RST       = 32'h0000_0000;
    localparam logic [NUM_IRQ-1:0] IRQ_EN_RST = 10'h3ff;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam int CH_STRIDE   = 'h40;
    localparam int OFF_PCTL    = 'h00;
    localparam int OFF_PCTR    = 'h10;
    localparam int OFF_FCTL    = 'h30;
    localparam int OFF_FCTR_LO = 'h34;
    localparam int OFF_FCTR_HI = 'h38;
    localparam logic [ADDR_W-1:0] ADDR_FRC_CLK = 8'h80;
    localparam logic [ADDR_W-1:0] ADDR_FRC_RD  = 8'h88;
    localparam logic [ADDR_W-1:0] ADDR_FRC_WR  = 8'h90;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ST  = 8'ha0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = 8'ha4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN  = 8'ha8;

    // ----------------------------------------------------------------
    // Carriers and state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } mccp_bus_s;

    typedef struct packed {
        logic [CTR_W-1:0] cnt;
        logic             ovf;
    } mccp_cnt_s;

    typedef struct packed {
        logic [NUM_IRQ-1:0] status;
        logic [NUM_IRQ-1:0] enable;
    } mccp_irq_s;

    typedef struct packed {
        logic [NUM_CH-1:0][NUM_PROG-1:0][31:0] pctl;
        logic [NUM_CH-1:0][31:0]               fctl;
        logic [DATA_W-1:0]                     rdata;
    } mccp_top_s;
endpackage

// ===== rtl/mccp_top.sv
/*
 Performance counters of a two-channel memory controller: per channel four
 programmable event counters and a fixed dram-clock counter, plus three
 free-running counters, an interrupt block and a plain register port.
 Assumes event increments, dram tick and power-down come from logic on clk.
*/
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module mccp_top
    import mccp_pkg::*;
#(
    parameter int NUM_EVENTS = 16
) (
    input  wire logic                                       clk,
    input  wire logic                                       nrst,
    input  wire mccp_bus_s                                  bus,
    output logic      [DATA_W-1:0]                          rdata,
    input  wire logic [NUM_CH-1:0][NUM_EVENTS-1:0][INC_W-1:0] event_inc,
    input  wire logic                                       dclk_tick,
    input  wire logic                                       ctrl_powered_down,
    input  wire logic [BYTE_W-1:0]                          rd_bytes,
    input  wire logic [BYTE_W-1:0]                          wr_bytes,
    output logic                                            monitoring_interrupt
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    mccp_top_s                            s_r;
    mccp_top_s                            s_nxt;
    logic [NUM_CH-1:0][NUM_CTR-1:0][CTR_W-1:0] cnt;
    logic [NUM_CH-1:0][NUM_CTR-1:0]       ovf;
    logic [NUM_CH-1:0][NUM_CTR-1:0]       ld_lo;
    logic [NUM_CH-1:0][NUM_CTR-1:0]       ld_hi;
    logic [NUM_CH-1:0][NUM_CTR-1:0]       clr;
    logic [NUM_IRQ-1:0]                   irq_set;
    logic [NUM_IRQ-1:0]                   irq_status;
    logic [NUM_IRQ-1:0]                   irq_enable;
    logic                                 irq_clr_wr;
    logic                                 irq_en_wr;
    logic [DATA_W-1:0]                    rd_val;
    logic [CTR_W-1:0]                     frc_clk;
    logic [CTR_W-1:0]                     frc_rd;
    logic [CTR_W-1:0]                     frc_wr;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] ra(input int c, input int off);
        return ADDR_W'(c * CH_STRIDE + off);
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
        return a == b;
    endfunction

    function automatic logic [DATA_W-1:0] lo_w(input logic [CTR_W-1:0] v);
        return v[DATA_W-1:0];
    endfunction

    function automatic logic [DATA_W-1:0] hi_w(input logic [CTR_W-1:0] v);
        return {{(DATA_W - HI_W){1'b0}}, v[CTR_W-1:DATA_W]};
    endfunction

    // ----------------------------------------------------------------
    // Register writes and reads
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        ld_lo = '0;
        ld_hi = '0;
        clr = '0;
        rd_val = '0;
        irq_clr_wr = 1'b0;
        irq_en_wr = 1'b0;
        if (bus.wr) begin
            for (int c = 0; c < NUM_CH; c++) begin
                for (int k = 0; k < NUM_PROG; k++) begin
                    if (hit(bus.addr, ra(c, OFF_PCTL + 4 * k))) begin
                        s_nxt.pctl[c][k] = bus.wdata & PROG_CTL_MASK;
                        clr[c][k] = bus.wdata[CTL_CLR_BIT];
                    end else if (hit(bus.addr, ra(c, OFF_PCTR + 8 * k))) begin
                        ld_lo[c][k] = 1'b1;
                    end else if (hit(bus.addr, ra(c, OFF_PCTR + 8 * k + 4))) begin
                        ld_hi[c][k] = 1'b1;
                    end
                end
                if (hit(bus.addr, ra(c, OFF_FCTL))) begin
                    s_nxt.fctl[c] = bus.wdata & FIX_CTL_MASK;
                    clr[c][FIX_IDX] = bus.wdata[CTL_CLR_BIT];
                end else if (hit(bus.addr, ra(c, OFF_FCTR_LO))) begin
                    ld_lo[c][FIX_IDX] = 1'b1;
                end else if (hit(bus.addr, ra(c, OFF_FCTR_HI))) begin
                    ld_hi[c][FIX_IDX] = 1'b1;
                end
            end
            // Free-running counter addresses take no write
            if (hit(bus.addr, ADDR_IRQ_CLR)) begin
                irq_clr_wr = 1'b1;
            end else if (hit(bus.addr, ADDR_IRQ_EN)) begin
                irq_en_wr = 1'b1;
            end
        end
        if (bus.rd) begin
            for (int c = 0; c < NUM_CH; c++) begin
                for (int k = 0; k < NUM_PROG; k++) begin
                    if (hit(bus.addr, ra(c, OFF_PCTL + 4 * k))) begin
                        rd_val = s_r.pctl[c][k];
                    end else if (hit(bus.addr, ra(c, OFF_PCTR + 8 * k))) begin
                        rd_val = lo_w(cnt[c][k]);
                    end else if (hit(bus.addr, ra(c, OFF_PCTR + 8 * k + 4))) begin
                        rd_val = hi_w(cnt[c][k]);
                    end
                end
                if (hit(bus.addr, ra(c, OFF_FCTL))) begin
                    rd_val = s_r.fctl[c];
                end else if (hit(bus.addr, ra(c, OFF_FCTR_LO))) begin
                    rd_val = lo_w(cnt[c][FIX_IDX]);
                end else if (hit(bus.addr, ra(c, OFF_FCTR_HI))) begin
                    rd_val = hi_w(cnt[c][FIX_IDX]);
                end
            end
            if (hit(bus.addr, ADDR_FRC_CLK)) begin
                rd_val = lo_w(frc_clk);
            end else if (hit(bus.addr, ADDR_FRC_CLK + 8'h04)) begin
                rd_val = hi_w(frc_clk);
            end else if (hit(bus.addr, ADDR_FRC_RD)) begin
                rd_val = lo_w(frc_rd);
            end else if (hit(bus.addr, ADDR_FRC_RD + 8'h04)) begin
                rd_val = hi_w(frc_rd);
            end else if (hit(bus.addr, ADDR_FRC_WR)) begin
                rd_val = lo_w(frc_wr);
            end else if (hit(bus.addr, ADDR_FRC_WR + 8'h04)) begin
                rd_val = hi_w(frc_wr);
            end else if (hit(bus.addr, ADDR_IRQ_ST)) begin
                rd_val = DATA_W'(irq_status);
            end else if (hit(bus.addr, ADDR_IRQ_EN)) begin
                rd_val = DATA_W'(irq_enable);
            end
        end
        s_nxt.rdata = rd_val;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{pctl: {(NUM_CH * NUM_PROG){CTL_RST}}, fctl: {NUM_CH{CTL_RST}}, rdata: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;

    // ----------------------------------------------------------------
    // Per-channel counters
    // ----------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        for (genvar k = 0; k < NUM_CTR; k++) begin : g_ctr
            logic [31:0]      ctl;
            logic [INC_W-1:0] inc;
            logic [INC_W-1:0] ev;
            if (k == FIX_IDX) begin : g_fix
                assign ctl = s_r.fctl[c];
                assign ev  = '0;
                assign inc = INC_W'(dclk_tick);
            end else begin : g_prog
                logic [EVSEL_W-1:0] sel;
                assign ctl = s_r.pctl[c][k];
                assign sel = ctl[EVSEL_W-1:0];
                assign ev  = (int'(sel) < NUM_EVENTS) ? event_inc[c][sel] : '0;
                assign inc = (ev > INC_W'(MAX_INC)) ? INC_W'(MAX_INC) : ev;
            end
            mccp_ctr #(.IW(INC_W)) u_ctr (
                .clk      (clk),
                .nrst     (nrst),
                .inc      (inc),
                .count_en (ctl[CTL_EN_BIT] && !ctrl_powered_down),
                .clr      (clr[c][k]),
                .ld_lo    (ld_lo[c][k]),
                .ld_hi    (ld_hi[c][k]),
                .wdata    (bus.wdata),
                .count    (cnt[c][k]),
                .ovf      (ovf[c][k])
            );
            assign irq_set[c * NUM_CTR + k] = ovf[c][k] && ctl[CTL_ARM_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Free-running counters
    // ----------------------------------------------------------------
    mccp_ctr #(.IW(1)) u_frc_clk (
        .clk      (clk),
        .nrst     (nrst),
        .inc      (dclk_tick),
        .count_en (!ctrl_powered_down),
        .clr      (1'b0),
        .ld_lo    (1'b0),
        .ld_hi    (1'b0),
        .wdata    (bus.wdata),
        .count    (frc_clk),
        .ovf      ()
    );

    mccp_ctr #(.IW(BYTE_W)) u_frc_rd (
        .clk      (clk),
        .nrst     (nrst),
        .inc      (rd_bytes),
        .count_en (!ctrl_powered_down),
        .clr      (1'b0),
        .ld_lo    (1'b0),
        .ld_hi    (1'b0),
        .wdata    (bus.wdata),
        .count    (frc_rd),
        .ovf      ()
    );

    mccp_ctr #(.IW(BYTE_W)) u_frc_wr (
        .clk      (clk),
        .nrst     (nrst),
        .inc      (wr_bytes),
        .count_en (!ctrl_powered_down),
        .clr      (1'b0),
        .ld_lo    (1'b0),
        .ld_hi    (1'b0),
        .wdata    (bus.wdata),
        .count    (frc_wr),
        .ovf      ()
    );

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    mccp_irq u_irq (
        .clk     (clk),
        .nrst    (nrst),
        .set     (irq_set),
        .clr_wr  (irq_clr_wr),
        .en_wr   (irq_en_wr),
        .wdata   (bus.wdata),
        .status  (irq_status),
        .enable  (irq_enable),
        .irq     (monitoring_interrupt)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_fixed_hold: assert property (
        !s_r.fctl[0][CTL_EN_BIT] && !ld_lo[0][FIX_IDX] && !ld_hi[0][FIX_IDX]
        && !clr[0][FIX_IDX] |=> $stable(cnt[0][FIX_IDX]))
        else $error("fixed counter moved while disabled");
    a_fixed_tick: assert property (
        s_r.fctl[1][CTL_EN_BIT] && !ctrl_powered_down && dclk_tick && !ld_lo[1][FIX_IDX]
        && !ld_hi[1][FIX_IDX] && !clr[1][FIX_IDX]
        |=> cnt[1][FIX_IDX] == $past(cnt[1][FIX_IDX]) + 1)
        else $error("fixed counter missed a tick");
    a_clear_strobe: assert property (
        clr[1][2] |=> cnt[1][2] == '0)
        else $error("clear strobe did not clear");
    a_ctr_load: assert property (
        bus.wr && hit(bus.addr, ra(0, OFF_PCTR)) |=> cnt[0][0][DATA_W-1:0] == $past(bus.wdata))
        else $error("counter load lost");
    a_inc_cap: assert property (
        !clr[0][1] && !ld_lo[0][1] && !ld_hi[0][1]
        |=> CTR_W'(cnt[0][1] - $past(cnt[0][1])) <= CTR_W'(MAX_INC))
        else $error("counter advanced more than eight");
    a_irq_arm: assert property (
        ovf[0][0] && s_r.pctl[0][0][CTL_ARM_BIT] |=> irq_status[0])
        else $error("armed overflow not flagged");
    a_irq_noarm: assert property (
        !s_r.fctl[0][CTL_ARM_BIT] && !irq_status[FIX_IDX] |=> !irq_status[FIX_IDX])
        else $error("unarmed overflow flagged");
    a_frc_hold: assert property (
        ctrl_powered_down |=> $stable(frc_clk) && $stable(frc_rd) && $stable(frc_wr))
        else $error("free counter moved in power down");
    a_frc_rdacc: assert property (
        !ctrl_powered_down |=> frc_rd == $past(frc_rd) + CTR_W'($past(rd_bytes)))
        else $error("read byte count wrong");
    a_frc_wracc: assert property (
        !ctrl_powered_down |=> frc_wr == $past(frc_wr) + CTR_W'($past(wr_bytes)))
        else $error("write byte count wrong");
    a_frc_dclk: assert property (
        !ctrl_powered_down |=> frc_clk == $past(frc_clk) + CTR_W'($past(dclk_tick)))
        else $error("dram clock count wrong");
    a_ctl_unused: assert property (
        bus.rd && hit(bus.addr, ra(0, OFF_FCTL)) |=> (rdata & ~FIX_CTL_MASK) == '0)
        else $error("unused control bits not zero");
    a_pctl_unused: assert property (
        bus.rd && hit(bus.addr, ra(0, OFF_PCTL + 12)) |=> (rdata & ~PROG_CTL_MASK) == '0)
        else $error("unused event control bits not zero");
    a_rdata_idle: assert property (
        !bus.rd |=> rdata == '0)
        else $error("read data outside read cycle");
    a_hi_load: assert property (
        bus.wr && hit(bus.addr, ra(1, OFF_PCTR + 20))
        |=> cnt[1][2][CTR_W-1:DATA_W] == HI_W'($past(bus.wdata)))
        else $error("counter high word load lost");
    a_sel_clamp: assert property (
        s_r.pctl[1][2][CTL_EN_BIT] && s_r.pctl[1][2][EVSEL_W-1:0] == 8'h03
        && event_inc[1][3] == 4'hf && !ctrl_powered_down
        && !ld_lo[1][2] && !ld_hi[1][2] && !clr[1][2]
        |=> cnt[1][2] == $past(cnt[1][2]) + CTR_W'(MAX_INC))
        else $error("selected event not clamped to eight");
    a_fixed_dclk_only: assert property (
        !dclk_tick && !ld_lo[0][FIX_IDX] && !ld_hi[0][FIX_IDX] && !clr[0][FIX_IDX]
        |=> $stable(cnt[0][FIX_IDX]))
        else $error("fixed counter moved without a tick");
    a_pdown_hold: assert property (
        ctrl_powered_down && !ld_lo[1][2] && !ld_hi[1][2] && !clr[1][2]
        |=> $stable(cnt[1][2]))
        else $error("event counter moved in power down");
    a_frc_nowrite: assert property (
        bus.wr && hit(bus.addr, ADDR_FRC_RD) && ctrl_powered_down |=> $stable(frc_rd))
        else $error("free counter took a write");
    a_prog_noarm: assert property (
        !s_r.pctl[0][0][CTL_ARM_BIT] && !irq_status[0] |=> !irq_status[0])
        else $error("unarmed event counter flagged");
    a_irq_clear: assert property (
        bus.wr && hit(bus.addr, ADDR_IRQ_CLR) && bus.wdata[0] && !irq_set[0]
        |=> !irq_status[0])
        else $error("status bit not cleared");
    a_irq_rise: assert property (
        $rose(monitoring_interrupt) |-> $past(irq_set) != '0 || $past(irq_en_wr))
        else $error("interrupt rose without cause");

    c_armed_ovf: cover property (ovf[0][0] && s_r.pctl[0][0][CTL_ARM_BIT]);
    c_clear:     cover property (clr[0][FIX_IDX]);
    c_power:     cover property (ctrl_powered_down ##1 !ctrl_powered_down);
    c_irq:       cover property (monitoring_interrupt);
    c_fix_wrap:  cover property (ovf[0][FIX_IDX]);
endmodule

// ===== test/mccp_top_tb.sv
/*
 Self-checking bench for mccp_top: register port tasks and directed tests.
 Assumes the package map, a 125 MHz clock and NUM_EVENTS of 16.
*/
`timescale 1ns/100ps
module mccp_top_tb import mccp_pkg::*;;
    logic                               clk;
    logic                               nrst;
    mccp_bus_s                          bus;
    logic [DATA_W-1:0]                  rdata;
    logic [NUM_CH-1:0][15:0][INC_W-1:0] ev;
    logic                               dtick;
    logic                               pdown;
    logic [BYTE_W-1:0]                  rb;
    logic [BYTE_W-1:0]                  wb;
    logic                               irq;
    int                                 failures;
    int                                 samples_checked;

    mccp_top #(.NUM_EVENTS(16)) u_dut (
        .clk                  (clk),
        .nrst                 (nrst),
        .bus                  (bus),
        .rdata                (rdata),
        .event_inc            (ev),
        .dclk_tick            (dtick),
        .ctrl_powered_down    (pdown),
        .rd_bytes             (rb),
        .wr_bytes             (wb),
        .monitoring_interrupt (irq)
    );

    always #4 clk = ~clk;

    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '{a, d, 1'b0, 1'b0};
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '{a, 32'h0, 1'b0, 1'b0};
        @(negedge clk);
        chk(rdata, e);
    endtask

    // Lets the staged event inputs be sampled n times, then idles them
    task automatic run(input int n);
        repeat (n) @(posedge clk);
        ev <= '0;
        dtick <= 1'b0;
        rb <= 8'h00;
        wb <= 8'h00;
    endtask

    task automatic test_done();
        $display("checks=%0d failures=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----
    // Tests
    // ----
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        bus = '0;
        ev = '0;
        dtick = 1'b0;
        pdown = 1'b0;
        rb = 8'h00;
        wb = 8'h00;
        failures = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rchk(8'h30, 32'h0);
        rchk(8'h74, 32'h0);
        rchk(ADDR_FRC_CLK, 32'h0);
        rchk(ADDR_IRQ_EN, 32'h3ff);
        rchk(8'hfc, 32'h0);
        $display("test reset done");
        wr(8'h0c, 32'hffff_ffff);
        rchk(8'h0c, 32'h0050_00ff);
        wr(8'h70, 32'hffff_ffff);
        rchk(8'h70, 32'h0050_0000);
        // Channel 1 counter 2 on event 3, neighbours must stay still
        wr(8'h48, 32'h0040_0003);
        wr(8'h64, 32'hffff_1234);
        rchk(8'h64, 32'h0000_1234);
        wr(8'h64, 32'h0);
        ev[1][3] <= 4'hf;
        ev[1][5] <= 4'h1;
        ev[0][3] <= 4'h1;
        run(3);
        rchk(8'h60, 32'd24);
        rchk(8'h20, 32'h0);
        rchk(8'h28, 32'h0);
        wr(8'h48, 32'h0048_0003);
        rchk(8'h60, 32'h0);
        $display("test programmable done");
        wr(8'h30, 32'h0040_0000);
        dtick <= 1'b1;
        rb <= 8'h07;
        wb <= 8'h09;
        run(5);
        rchk(8'h34, 32'd5);
        rchk(ADDR_FRC_CLK, 32'd5);
        rchk(ADDR_FRC_RD, 32'd35);
        rchk(ADDR_FRC_WR, 32'd45);
        @(posedge clk);
        pdown <= 1'b1;
        dtick <= 1'b1;
        rb <= 8'h07;
        wb <= 8'h09;
        run(4);
        wr(ADDR_FRC_RD, 32'h1234);
        rchk(ADDR_FRC_CLK, 32'd5);
        rchk(ADDR_FRC_RD, 32'd35);
        rchk(ADDR_FRC_WR, 32'd45);
        @(posedge clk);
        pdown <= 1'b0;
        wr(8'h30, 32'h0048_0000);
        rchk(8'h34, 32'h0);
        rchk(8'h30, 32'h0040_0000);
        $display("test fixed and free done");
        // Wrap with arm set but interrupt masked, then unmask and clear
        wr(ADDR_IRQ_EN, 32'h0);
        wr(8'h10, 32'hffff_ffff);
        wr(8'h14, 32'h0000_ffff);
        wr(8'h00, 32'h0050_0000);
        ev[0][0] <= 4'h2;
        run(1);
        rchk(8'h10, 32'h1);
        rchk(8'h14, 32'h0);
        rchk(ADDR_IRQ_ST, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_EN, 32'h3ff);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(ADDR_IRQ_CLR, 32'h1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        // Fixed counter wraps without arm: no status
        wr(8'h34, 32'hffff_ffff);
        wr(8'h38, 32'h0000_ffff);
        dtick <= 1'b1;
        run(1);
        rchk(8'h34, 32'h0);
        rchk(ADDR_IRQ_ST, 32'h0);
        $display("test overflow done");
        test_done();
    end

    initial begin
        #40000;
        failures++;
        test_done();
    end
endmodule
